// ### agd_top.sv
`timescale 1ns/10ps
// Purpose: Channel back end: gain, dc correction, output select and buffers
// Assumes: Samples arrive on the sampling clock; link clock is separate
// Notes: Control bits are plain ports; no register bus
module agd_top
  import agd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic [1:0] digital_mode,
  input wire logic [GAIN_W-1:0] gain_code,
  input wire logic dc_correction_on,
  input wire logic [TAU_W-1:0] dc_loop_tau_sel,
  input wire logic dc_estimate_hold,
  input wire logic ddr_select,
  input wire logic [SWING_W-1:0] swing_code,
  input wire logic data_buffer_double_drive,
  input wire logic clock_buffer_double_drive,
  input wire logic [NOTCH_W-1:0] noise_notch_select,
  output logic [SAMPLE_W-1:0] sample_out,
  output logic [PAIR_N-1:0] pair_rise,
  output logic [PAIR_N-1:0] pair_fall,
  output logic [SAMPLE_W-1:0] cmos_data,
  output logic ddr_mode,
  output logic clkout,
  output logic gain_active,
  output logic dc_active,
  output logic [SAMPLE_W-1:0] dc_estimate,
  output logic notch_active,
  output logic [NOTCH_W-1:0] notch_code,
  output logic [SWING_W-1:0] swing_setting,
  output logic data_drive_x2,
  output logic clock_drive_x2
);
  agd_link_if lk();

  // ==========================================================
  // Mode decoding
  // ==========================================================
  wire mode_on = (digital_mode == 2'h3);
  wire mode2_only = (digital_mode == 2'h2);
  wire [GAIN_W-1:0] gain_eff = (gain_code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : gain_code;
  wire tau_ok = (dc_loop_tau_sel <= TAU_CODE_MAX);
  wire notch_ok = (noise_notch_select <= NOTCH_CODE_MAX);

  logic gain_en_reg;
  logic [GAIN_W-1:0] gain_reg;
  logic [TAU_W-1:0] tau_reg;
  agd_loop_e loop_reg;
  agd_loop_e loop_next;

  // Correction runs only once both mode bits are set by the host
  always_comb
  begin
    loop_next = loop_reg;
    case (loop_reg)
      AGD_OFF: if (mode_on && dc_correction_on) loop_next = AGD_ON;
      AGD_ON:
      begin
        if (!(mode_on && dc_correction_on)) loop_next = AGD_OFF;
        else if (dc_estimate_hold) loop_next = AGD_HOLD;
      end
      AGD_HOLD:
      begin
        if (!(mode_on && dc_correction_on)) loop_next = AGD_OFF;
        else if (!dc_estimate_hold) loop_next = AGD_ON;
      end
      default: loop_next = AGD_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      loop_reg <= AGD_OFF;
      gain_en_reg <= 1'b0;
      gain_reg <= '0;
      tau_reg <= '0;
    end
    else if (clk_en)
    begin
      loop_reg <= loop_next;
      gain_en_reg <= mode_on;
      gain_reg <= mode_on ? gain_eff : '0;
      if (tau_ok)
        tau_reg <= dc_loop_tau_sel;
    end
  end

  // ==========================================================
  // Offset estimator: acc += (x - acc) >> (20 + code)
  // ==========================================================
  // Accumulator keeps enough fraction bits that the 2G setting
  // still moves; narrower would stall on small errors.
  logic signed [ACC_W-1:0] acc_reg;
  wire signed [ACC_W-1:0] x_ext = ACC_W'(signed'(sample_in)) <<< ACC_FRAC;
  wire signed [ACC_W-1:0] err = x_ext - acc_reg;
  wire [5:0] shamt = 6'(TAU_BASE_LOG2) + 6'(tau_reg);
  wire signed [ACC_W-1:0] step = err >>> shamt;
  wire signed [SAMPLE_W-1:0] est = acc_reg[ACC_FRAC +: SAMPLE_W];

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      acc_reg <= '0;
    else if (clk_en && loop_reg == AGD_ON)
      acc_reg <= acc_reg + step;
  end

  // ==========================================================
  // Datapath: subtract estimate, then fine gain in 1/64 units
  // ==========================================================
  wire signed [SAMPLE_W+1:0] corr = (loop_reg != AGD_OFF)
    ? (SAMPLE_W+2)'(signed'(sample_in)) - (SAMPLE_W+2)'(est)
    : (SAMPLE_W+2)'(signed'(sample_in));
  // Multiplier in 1/64 units, one entry per 0.5 dB step. A table costs a few
  // gates more than a straight line but lands the top code on a true 6 dB.
  localparam logic [7:0] GAIN_MULT [16] = '{8'h40, 8'h44, 8'h48, 8'h4c, 8'h51, 8'h55,
    8'h5a, 8'h60, 8'h65, 8'h6b, 8'h72, 8'h79, 8'h80, 8'h80, 8'h80, 8'h80};
  wire [7:0] gain_mult = GAIN_MULT[gain_reg];
  wire signed [SAMPLE_W+10:0] prod = (SAMPLE_W+11)'(corr) * signed'({1'b0, gain_mult});
  wire signed [SAMPLE_W+10:0] scaled = prod >>> GAIN_FRAC;
  wire signed [SAMPLE_W-1:0] sat_hi = {1'b0, {(SAMPLE_W-1){1'b1}}};
  wire signed [SAMPLE_W-1:0] sat_lo = {1'b1, {(SAMPLE_W-1){1'b0}}};
  wire signed [SAMPLE_W-1:0] result = (scaled > (SAMPLE_W+11)'(sat_hi)) ? sat_hi
    : (scaled < (SAMPLE_W+11)'(sat_lo)) ? sat_lo : scaled[SAMPLE_W-1:0];

  // ==========================================================
  // Hand-off to the link domain
  // ==========================================================
  logic [SAMPLE_W-1:0] word_reg;
  logic req_reg;
  logic [2:0] ack_sync_reg;
  // The acknowledge comes from the link clock. It counts only once the second
  // and third stages agree, so a metastable first stage never moves the word
  // while the far side may still be copying it.
  wire ack_settled = (ack_sync_reg[1] == ack_sync_reg[2]);
  wire link_idle = ack_settled && (ack_sync_reg[2] == req_reg);
  assign lk.word = word_reg;
  assign lk.req_tgl = req_reg;
  assign lk.ddr_sel = ddr_select; // level, resynchronised at link end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      word_reg <= '0;
      req_reg <= 1'b0;
      ack_sync_reg <= '0;
      sample_out <= '0;
    end
    else if (clk_en)
    begin
      ack_sync_reg <= {ack_sync_reg[1:0], lk.ack_tgl};
      sample_out <= result;
      if (link_idle)
      begin
        word_reg <= result;
        req_reg <= ~req_reg;
      end
    end
  end

  // ==========================================================
  // Status and buffer settings
  // ==========================================================
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      gain_active <= 1'b0;
      dc_active <= 1'b0;
      dc_estimate <= '0;
      notch_active <= 1'b0;
      notch_code <= '0;
      swing_setting <= SWING_RESET;
      data_drive_x2 <= 1'b0;
      clock_drive_x2 <= 1'b0;
    end
    else if (clk_en)
    begin
      gain_active <= gain_en_reg;
      dc_active <= (loop_reg != AGD_OFF);
      dc_estimate <= est;
      notch_active <= mode2_only;
      if (!digital_mode[1] && notch_ok)
        notch_code <= noise_notch_select;
      swing_setting <= swing_code;
      data_drive_x2 <= data_buffer_double_drive;
      clock_drive_x2 <= clock_buffer_double_drive;
    end
  end

  agd_link_out u_link (
    .link_clk(link_clk),
    .rstn(rstn),
    .lk(lk.link),
    .pair_rise(pair_rise),
    .pair_fall(pair_fall),
    .cmos_data(cmos_data),
    .ddr_mode(ddr_mode),
    .clkout(clkout)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  a_loop_reset_off: assert property (@(posedge clock) disable iff (!rstn)
    (clk_en && !mode_on)
    |=> (loop_reg == AGD_OFF))
    else $error("correction active without mode");
  a_hold_freezes: assert property (@(posedge clock) disable iff (!rstn)
    (loop_reg == AGD_HOLD && clk_en)
    |=> $stable(acc_reg))
    else $error("estimate moved");
  a_hold_applies: assert property (@(posedge clock) disable iff (!rstn)
    (loop_reg == AGD_HOLD && clk_en)
    |=> (dc_estimate == $past(est)))
    else $error("held estimate not shown");
  a_gain_zero_db: assert property (@(posedge clock) disable iff (!rstn)
    (!mode_on && clk_en)
    |=> (gain_reg == '0))
    else $error("gain not 0 dB");
  a_gain_unity: assert property (@(posedge clock) disable iff (!rstn)
    (gain_reg == '0)
    |-> (gain_mult == 8'h40))
    else $error("0 dB multiplier wrong");
  a_gain_max_code: assert property (@(posedge clock) disable iff (!rstn)
    (gain_reg <= GAIN_CODE_MAX))
    else $error("gain code out of range");
  a_gain_six_db: assert property (@(posedge clock) disable iff (!rstn)
    (gain_reg == GAIN_CODE_MAX)
    |-> (gain_mult == 8'h80))
    else $error("top gain not 6 dB");
  a_tau_legal: assert property (@(posedge clock) disable iff (!rstn)
    (tau_reg <= TAU_CODE_MAX))
    else $error("reserved tau applied");
  a_tau_reserved: assert property (@(posedge clock) disable iff (!rstn)
    (clk_en && !tau_ok)
    |=> $stable(tau_reg))
    else $error("reserved tau taken");
  a_notch_legal: assert property (@(posedge clock) disable iff (!rstn)
    (notch_code <= NOTCH_CODE_MAX))
    else $error("notch code out of range");
  a_notch_frozen: assert property (@(posedge clock) disable iff (!rstn)
    (clk_en && digital_mode[1])
    |=> $stable(notch_code))
    else $error("notch code changed in mode");
  a_out_follows: assert property (@(posedge clock) disable iff (!rstn)
    clk_en
    |=> (sample_out == $past(result)))
    else $error("output lost sample");
  a_dc_bypass: assert property (@(posedge clock) disable iff (!rstn)
    (loop_reg == AGD_OFF && gain_reg == '0)
    |-> (result == sample_in))
    else $error("sample altered while bypassed");
  a_word_held: assert property (@(posedge clock) disable iff (!rstn)
    (!link_idle)
    |=> $stable(word_reg))
    else $error("link word moved in transfer");
  a_enable_freeze: assert property (@(posedge clock) disable iff (!rstn)
    (!clk_en)
    |=> ($stable(sample_out) && $stable(acc_reg) && $stable(req_reg)))
    else $error("state moved while disabled");
  a_drive_follow: assert property (@(posedge clock) disable iff (!rstn)
    clk_en ##1 clk_en
    |=> (clock_drive_x2 == $past(clock_buffer_double_drive)))
    else $error("clock drive stale");
  c_loop_on: cover property (@(posedge clock) disable iff (!rstn) loop_reg == AGD_ON);
  c_loop_hold: cover property (@(posedge clock) disable iff (!rstn) loop_reg == AGD_HOLD);
  c_gain_max: cover property (@(posedge clock) disable iff (!rstn) gain_reg == GAIN_CODE_MAX);
  c_enable_low: cover property (@(posedge clock) disable iff (!rstn) !clk_en);
  c_word_busy: cover property (@(posedge clock) disable iff (!rstn) !link_idle);
endmodule // agd_top

// ### agd_pkg.sv
// Purpose: Shared constants and types for the ADC back-end channel block
// Assumes: One channel of 11-bit samples on a 250 MHz sampling clock
// Notes: Summary of operation below
//
// Summary of operation
// - Fine gain 0 to 6 dB, 0.5 dB steps
// - Gain off after reset; enable starts 0 dB
// - Enabled correction subtracts estimate every sample
// - Tau code 0..11 gives 1M..2G cycles
// - Hold bit freezes estimate, keeps applying it
// - Offset correction off after any reset
// - 11-bit samples with shared synchronous output clock
// - Select bit picks DDR pairs or CMOS
// - DDR sends two bits per pair per clock
// - Swing field spans 125 to 570 mV
// - Default 100 ohm; strength bits double drive
// - Notch codes 0 to 54 accepted
// - Notch filter off after reset
package agd_pkg;
  localparam int SAMPLE_W = 11;
  localparam int PAIR_N = 6;
  localparam int GAIN_W = 4;
  localparam logic [GAIN_W-1:0] GAIN_CODE_MAX = 4'hc;
  localparam int GAIN_FRAC = 6;
  localparam int TAU_W = 4;
  localparam logic [TAU_W-1:0] TAU_CODE_MAX = 4'hb;
  localparam int TAU_BASE_LOG2 = 20;
  localparam int ACC_FRAC = TAU_BASE_LOG2 + 11;
  localparam int ACC_W = SAMPLE_W + ACC_FRAC + 2;
  localparam int NOTCH_W = 6;
  localparam logic [NOTCH_W-1:0] NOTCH_CODE_MAX = 6'h36;
  localparam int SWING_W = 3;
  localparam logic [SWING_W-1:0] SWING_RESET = 3'h3;
  localparam int SWING_MIN_MV = 125;
  localparam int SWING_MAX_MV = 570;
  localparam int SWING_NOM_MV = 350;
  localparam logic [1:0] MODE_RESET = 2'h0;
  typedef enum logic [1:0] {AGD_OFF, AGD_ON, AGD_HOLD} agd_loop_e;
endpackage

// ### agd_link_if.sv
`timescale 1ns/10ps
// Purpose: Carrier for samples handed from the core to the link end
// Assumes: Words cross by a toggle handshake
// Notes: Word held stable while toggle differs from acknowledge
interface agd_link_if;
  import agd_pkg::*;
  logic [SAMPLE_W-1:0] word;
  logic req_tgl;
  logic ack_tgl;
  logic ddr_sel;
  modport core (output word, output req_tgl, output ddr_sel, input ack_tgl);
  modport link (input word, input req_tgl, input ddr_sel, output ack_tgl);
endinterface

// ### agd_link_out.sv
`timescale 1ns/10ps
// Purpose: Link-side output serialiser on the link clock
// Assumes: Core holds word until acknowledged
// Notes: Outputs are registered on the link clock
module agd_link_out
  import agd_pkg::*;
(
  input wire logic link_clk,
  input wire logic rstn,
  agd_link_if.link lk,
  output logic [PAIR_N-1:0] pair_rise,
  output logic [PAIR_N-1:0] pair_fall,
  output logic [SAMPLE_W-1:0] cmos_data,
  output logic ddr_mode,
  output logic clkout
);
  logic [2:0] req_sync_reg;
  logic [2:0] sel_sync_reg;
  logic [SAMPLE_W-1:0] hold_reg;
  logic ack_reg;
  wire new_word = (req_sync_reg[1] == req_sync_reg[2]) && (req_sync_reg[2] != ack_reg);
  wire [SAMPLE_W:0] padded = {1'b0, hold_reg};
  assign lk.ack_tgl = ack_reg;

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_sync_reg <= '0;
      sel_sync_reg <= '0;
      ack_reg <= 1'b0;
      hold_reg <= '0;
    end
    else
    begin
      req_sync_reg <= {req_sync_reg[1:0], lk.req_tgl};
      sel_sync_reg <= {sel_sync_reg[1:0], lk.ddr_sel};
      if (new_word)
      begin
        hold_reg <= lk.word;
        ack_reg <= req_sync_reg[2];
      end
    end
  end

  // ==========================================================
  // Pins: DDR pairs carry even bit on rising, odd on falling
  // ==========================================================
  genvar i;
  generate
    for (i = 0; i < PAIR_N; i++)
    begin : g_pair
      always_ff @(posedge link_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          pair_rise[i] <= 1'b0;
          pair_fall[i] <= 1'b0;
        end
        else
        begin
          pair_rise[i] <= padded[2*i];
          pair_fall[i] <= padded[2*i+1];
        end
      end
    end
  endgenerate

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmos_data <= '0;
      ddr_mode <= 1'b1;
      clkout <= 1'b0;
    end
    else
    begin
      if (sel_sync_reg[1] == sel_sync_reg[2])
        ddr_mode <= sel_sync_reg[2];
      cmos_data <= hold_reg;
      clkout <= ~clkout;
    end
  end
endmodule // agd_link_out

// ### agd_rx_model.sv
`timescale 1ns/10ps
// Purpose: Far-end receiver model for the channel link outputs
// Assumes: Data and output clock leave on the same link clock edge
// Notes: Rebuilds the word on each output clock edge
module agd_rx_model
  import agd_pkg::*;
(
  input wire logic [PAIR_N-1:0] pair_rise,
  input wire logic [PAIR_N-1:0] pair_fall,
  input wire logic [SAMPLE_W-1:0] cmos_data,
  input wire logic ddr_mode,
  input wire logic clkout,
  output logic [SAMPLE_W-1:0] rx_word,
  output int rx_edges
);
  logic [2*PAIR_N-1:0] merged;
  int edge_cnt = 0;
  assign rx_edges = edge_cnt;
  // ==========================================
  // Capture
  always_comb
  begin
    for (int i = 0; i < PAIR_N; i++)
    begin
      merged[2*i] = pair_rise[i];
      merged[2*i+1] = pair_fall[i];
    end
  end
  // Both edges count, as a DDR receiver latches on each
  always @(clkout)
  begin
    edge_cnt = edge_cnt + 1;
    rx_word = ddr_mode ? merged[SAMPLE_W-1:0] : cmos_data;
  end
endmodule // agd_rx_model

// ### adc_gain_offset_output_test.sv
`timescale 1ns/10ps
// Purpose: Self-checking bench for the channel back end
// Assumes: Gain code 0 passes samples unchanged
// Notes: Estimator checks use short runs against a 1M-cycle time constant
module adc_gain_offset_output_test;
  import agd_pkg::*;
  typedef struct packed {logic [1:0] mode; logic [2:0] sw; logic dd; logic cd;
    logic [2:0] act;} agd_row_s;
  localparam agd_row_s rows [4] = '{'{2'h0, 3'h0, 1'b0, 1'b0, 3'h0},
    '{2'h1, 3'h7, 1'b1, 1'b0, 3'h0}, '{2'h2, 3'h5, 1'b0, 1'b1, 3'h1},
    '{2'h3, 3'h1, 1'b1, 1'b1, 3'h6}};
  logic clock, rstn, clk_en, link_clk, dc_correction_on, dc_estimate_hold, ddr_select;
  logic data_buffer_double_drive, clock_buffer_double_drive, ddr_mode, clkout;
  logic gain_active, dc_active, notch_active, data_drive_x2, clock_drive_x2;
  logic [SAMPLE_W-1:0] sample_in, sample_out, cmos_data, dc_estimate, rx_word, hi;
  logic [1:0] digital_mode;
  logic [GAIN_W-1:0] gain_code;
  logic [TAU_W-1:0] dc_loop_tau_sel;
  logic [SWING_W-1:0] swing_code, swing_setting;
  logic [NOTCH_W-1:0] noise_notch_select, notch_code;
  logic [PAIR_N-1:0] pair_rise, pair_fall;
  int rx_edges, edges, mismatches = 0, total_checks = 0;
  agd_top dut (.clock(clock), .rstn(rstn), .clk_en(clk_en), .link_clk(link_clk),
    .sample_in(sample_in), .digital_mode(digital_mode), .gain_code(gain_code),
    .dc_correction_on(dc_correction_on), .dc_loop_tau_sel(dc_loop_tau_sel),
    .dc_estimate_hold(dc_estimate_hold), .ddr_select(ddr_select), .swing_code(swing_code),
    .data_buffer_double_drive(data_buffer_double_drive),
    .clock_buffer_double_drive(clock_buffer_double_drive),
    .noise_notch_select(noise_notch_select), .sample_out(sample_out), .pair_rise(pair_rise),
    .pair_fall(pair_fall), .cmos_data(cmos_data), .ddr_mode(ddr_mode), .clkout(clkout),
    .gain_active(gain_active), .dc_active(dc_active), .dc_estimate(dc_estimate),
    .notch_active(notch_active), .notch_code(notch_code), .swing_setting(swing_setting),
    .data_drive_x2(data_drive_x2), .clock_drive_x2(clock_drive_x2));
  agd_rx_model rx (.pair_rise(pair_rise), .pair_fall(pair_fall), .cmos_data(cmos_data),
    .ddr_mode(ddr_mode), .clkout(clkout), .rx_word(rx_word), .rx_edges(rx_edges));
  // ==========================================
  // Clocks, watchdog and checks
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial
  begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  initial
  begin
    #200000;
    mismatches++;
    close_out();
  end
  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_vec(input string what, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_defaults;
    check_bit("gain_active", 1'b0, gain_active);
    check_bit("dc_active", 1'b0, dc_active);
    check_bit("notch_active", 1'b0, notch_active);
    check_bit("data_drive_x2", 1'b0, data_drive_x2);
    check_bit("clock_drive_x2", 1'b0, clock_drive_x2);
    check_vec("swing_setting", 11'(SWING_RESET), 11'(swing_setting));
    check_bit("ddr_mode", 1'b1, ddr_mode);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial
  begin
    rstn = 1'b0;
    clk_en = 1'b1;
    sample_in = 11'h155;
    digital_mode = 2'h0;
    gain_code = 4'h0;
    dc_correction_on = 1'b0;
    dc_loop_tau_sel = 4'h0;
    dc_estimate_hold = 1'b0;
    ddr_select = 1'b1;
    swing_code = 3'h7;
    data_buffer_double_drive = 1'b1;
    clock_buffer_double_drive = 1'b1;
    noise_notch_select = 6'h23;
    ticks(4);
    check_defaults();
    rstn = 1'b1;
    ticks(2);
    for (int r = 0; r < 4; r++)
    begin
      dc_correction_on = 1'b0;
      digital_mode = rows[r].mode;
      swing_code = rows[r].sw;
      data_buffer_double_drive = rows[r].dd;
      clock_buffer_double_drive = rows[r].cd;
      ticks(1);
      dc_correction_on = 1'b1;
      ticks(3);
      check_bit("gain_active", rows[r].act[2], gain_active);
      check_bit("dc_active", rows[r].act[1], dc_active);
      check_bit("notch_active", rows[r].act[0], notch_active);
      check_vec("swing_setting", 11'(rows[r].sw), 11'(swing_setting));
      check_bit("data_drive_x2", rows[r].dd, data_drive_x2);
      check_bit("clock_drive_x2", rows[r].cd, clock_drive_x2);
      if (rows[r].mode != 2'h2)
        check_vec("sample_out", sample_in, sample_out);
    end
    dc_correction_on = 1'b0;
    sample_in = 11'h040;
    gain_code = 4'hc;
    ticks(4);
    hi = sample_out;
    check_bit("gain_top", 1'b1, hi >= 11'h07f && hi <= 11'h080);
    gain_code = 4'hf;
    ticks(4);
    check_vec("gain_clamp", hi, sample_out);
    gain_code = 4'h0;
    sample_in = 11'h3e8;
    ticks(2);
    dc_loop_tau_sel = 4'hc;
    dc_correction_on = 1'b1;
    ticks(4000);
    dc_estimate_hold = 1'b1;
    ticks(2);
    hi = dc_estimate;
    // Tau code 0 allows at most 1000*4002/2^20 counts of drift here
    check_bit("estimate_range", 1'b1, hi != 0 && hi <= 11'h004);
    ticks(2000);
    check_vec("held_estimate", hi, dc_estimate);
    check_vec("corrected", sample_in - hi, sample_out);
    dc_correction_on = 1'b0;
    ticks(3);
    check_bit("dc_off", 1'b0, dc_active);
    check_vec("uncorrected", sample_in, sample_out);
    digital_mode = 2'h0;
    noise_notch_select = 6'h36;
    ticks(2);
    digital_mode = 2'h2;
    ticks(3);
    check_vec("notch_code", 11'h036, 11'(notch_code));
    noise_notch_select = 6'h24;
    ticks(3);
    check_vec("notch_locked", 11'h036, 11'(notch_code));
    digital_mode = 2'h0;
    noise_notch_select = 6'h37;
    ticks(3);
    check_vec("notch_reject", 11'h036, 11'(notch_code));
    clk_en = 1'b0;
    swing_code = 3'h2;
    ticks(3);
    check_vec("swing_frozen", 11'h001, 11'(swing_setting));
    clk_en = 1'b1;
    ticks(2);
    check_vec("swing_thawed", 11'h002, 11'(swing_setting));
    sample_in = 11'h2a5;
    ticks(40);
    check_vec("ddr_word", 11'h2a5, rx_word);
    ddr_select = 1'b0;
    sample_in = 11'h5a3;
    ticks(40);
    check_vec("cmos_word", 11'h5a3, rx_word);
    check_bit("ddr_mode_off", 1'b0, ddr_mode);
    edges = rx_edges;
    ticks(10);
    check_bit("clkout_runs", 1'b1, rx_edges > edges);
    rstn = 1'b0;
    ticks(2);
    check_defaults();
    rstn = 1'b1;
    ticks(2);
    close_out();
  end
endmodule // adc_gain_offset_output_test
